/* lxb_device.sv */
// Device end: per-bank state tracking and masked write capture
`timescale 1ns/100ps
`default_nettype none
`include "lxb_defs.svh"
module lxb_device #(
  parameter int BANKS = `LXB_BANKS
) (
  input wire logic clk,
  input wire logic rst_n,
  lxb_link_if.dev link,
  output logic [4*BANKS-1:0] bank_state,
  output logic all_idle,
  output logic any_burst,
  output logic [`LXB_DQ_W-1:0] wr_data,
  output logic wr_store,
  output logic [`LXB_BANK_W-1:0] wr_bank
);
  logic cke_prev_reg;
  logic [`LXB_CNT_W-1:0] exit_reg;
  logic go;
  logic [BANKS-1:0] idle_v;
  logic [BANKS-1:0] burst_v;
  logic [BANKS-1:0] active_v;
  logic [`LXB_BANK_W-1:0] beat_bank;
  logic beat_ok;
  logic [`LXB_BANK_W-1:0] burst_bank_reg;
  logic [`LXB_DQ_W-1:0] wr_data_reg;
  logic wr_store_reg;
  logic [`LXB_BANK_W-1:0] wr_bank_reg;

  // Exit time counts from the first edge that sees clock enable high again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_reg <= 1'b0;
      exit_reg <= `LXB_T_EXIT;
    end else begin
      cke_prev_reg <= link.cke;
      if (!link.cke) begin
        exit_reg <= `LXB_T_EXIT;
      end else if (exit_reg != 8'h00) begin
        exit_reg <= exit_reg - 8'h01;
      end
    end
  end
  assign go = cke_prev_reg && link.cke && (exit_reg == 8'h00); // R1

  // Burst terminate follows the most recent burst, never a named bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_bank_reg <= '0;
    end else if (go && (link.cmd == `LXB_CMD_RD || link.cmd == `LXB_CMD_WR)) begin
      burst_bank_reg <= link.bank; // R6
    end
  end

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      lxb_pkg::lxb_state_t st_reg;
      lxb_pkg::lxb_state_t ret_reg;
      logic [`LXB_CNT_W-1:0] t_reg;
      logic ap_reg;
      logic hit;
      logic pend_rcd_reg;
      logic pend_rp_reg;
      logic [`LXB_CNT_W-1:0] pend_t_reg;
      assign hit = go && (link.bank == `LXB_BANK_W'(g));
      assign active_v[g] = (st_reg == lxb_pkg::LXB_ACTIVE);
      assign bank_state[4*g+3:4*g] = st_reg;
      assign idle_v[g] = (st_reg == lxb_pkg::LXB_IDLE);
      assign burst_v[g] = (st_reg == lxb_pkg::LXB_READING) ||
                          (st_reg == lxb_pkg::LXB_WRITING);
      // One record per bank; only all-bank commands touch every record
      always_ff @(posedge clk or negedge rst_n) begin // R23
        if (!rst_n) begin
          st_reg <= lxb_pkg::LXB_POWER_ON;
          ret_reg <= lxb_pkg::LXB_IDLE;
          t_reg <= '0;
          ap_reg <= 1'b0;
          pend_rcd_reg <= 1'b0;
          pend_rp_reg <= 1'b0;
          pend_t_reg <= '0;
        end else begin
          if (t_reg != 8'h00) t_reg <= t_reg - 8'h01;
          if (pend_t_reg != 8'h00) pend_t_reg <= pend_t_reg - 8'h01;
          if (go && link.cmd == `LXB_CMD_RESET && st_reg == lxb_pkg::LXB_POWER_ON) begin
            st_reg <= lxb_pkg::LXB_RESETTING; // R18
            t_reg <= `LXB_T_RESET;
          end else if (go && link.cmd == `LXB_CMD_MRW && st_reg == lxb_pkg::LXB_IDLE) begin
            st_reg <= lxb_pkg::LXB_MR_WRITING; // R5
            t_reg <= `LXB_T_MRW;
          end else if (go && link.cmd == `LXB_CMD_REF && st_reg == lxb_pkg::LXB_IDLE) begin
            st_reg <= lxb_pkg::LXB_REFRESHING; // R5
            t_reg <= `LXB_T_MRW;
          end else if (go && link.cmd == `LXB_CMD_PREA) begin
            st_reg <= lxb_pkg::LXB_PRECHARGING; // R11
            t_reg <= `LXB_T_RP;
            ap_reg <= 1'b0;
          end else if (go && link.cmd == `LXB_CMD_MRR &&
                       st_reg != lxb_pkg::LXB_READING &&
                       st_reg != lxb_pkg::LXB_WRITING &&
                       st_reg != lxb_pkg::LXB_POWER_ON) begin
            // Pending delays keep running across the read
            st_reg <= lxb_pkg::LXB_MR_READING; // R12 R13
            t_reg <= `LXB_T_MRR;
            ret_reg <= (st_reg == lxb_pkg::LXB_ACTIVATING) ? lxb_pkg::LXB_ACTIVE :
                       (st_reg == lxb_pkg::LXB_PRECHARGING) ? lxb_pkg::LXB_IDLE : st_reg;
            pend_rcd_reg <= (st_reg == lxb_pkg::LXB_ACTIVATING);
            pend_rp_reg <= (st_reg == lxb_pkg::LXB_PRECHARGING);
            pend_t_reg <= t_reg; // R14
          end else if (go && link.cmd == `LXB_CMD_BST &&
                       burst_bank_reg == `LXB_BANK_W'(g) && burst_v[g]) begin
            st_reg <= lxb_pkg::LXB_ACTIVE; // R6
          end else if (hit && link.cmd == `LXB_CMD_ACT && st_reg == lxb_pkg::LXB_IDLE) begin
            st_reg <= lxb_pkg::LXB_ACTIVATING; // R20
            t_reg <= `LXB_T_RCD;
          end else if (hit && (link.cmd == `LXB_CMD_RD || link.cmd == `LXB_CMD_WR) &&
                       (st_reg == lxb_pkg::LXB_ACTIVE || burst_v[g])) begin
            st_reg <= (link.cmd == `LXB_CMD_RD) ? lxb_pkg::LXB_READING :
                      lxb_pkg::LXB_WRITING; // R10 R20
            t_reg <= `LXB_T_BURST;
            ap_reg <= link.auto_pre; // R10
          end else if (hit && link.cmd == `LXB_CMD_PRE &&
                       st_reg != lxb_pkg::LXB_MR_READING &&
                       st_reg != lxb_pkg::LXB_MR_WRITING &&
                       st_reg != lxb_pkg::LXB_POWER_ON &&
                       st_reg != lxb_pkg::LXB_RESETTING) begin
            st_reg <= lxb_pkg::LXB_PRECHARGING; // R20
            t_reg <= `LXB_T_RP;
            ap_reg <= 1'b0;
          end else if (t_reg == 8'h00) begin
            unique case (st_reg)
              lxb_pkg::LXB_ACTIVATING: st_reg <= lxb_pkg::LXB_ACTIVE; // R3
              lxb_pkg::LXB_PRECHARGING: st_reg <= lxb_pkg::LXB_IDLE; // R2
              lxb_pkg::LXB_MR_WRITING: st_reg <= lxb_pkg::LXB_IDLE; // R8
              lxb_pkg::LXB_REFRESHING: st_reg <= lxb_pkg::LXB_IDLE;
              lxb_pkg::LXB_RESETTING: st_reg <= lxb_pkg::LXB_IDLE;
              lxb_pkg::LXB_MR_READING: begin
                // A pending delay that has not run out is resumed
                if (pend_rcd_reg && pend_t_reg != 8'h00) begin
                  st_reg <= lxb_pkg::LXB_ACTIVATING; // R14
                  t_reg <= pend_t_reg;
                end else if (pend_rp_reg && pend_t_reg != 8'h00) begin
                  st_reg <= lxb_pkg::LXB_PRECHARGING; // R14
                  t_reg <= pend_t_reg;
                end else begin
                  st_reg <= ret_reg; // R8
                end
                pend_rcd_reg <= 1'b0;
                pend_rp_reg <= 1'b0;
              end
              lxb_pkg::LXB_READING, lxb_pkg::LXB_WRITING: begin
                if (ap_reg) begin
                  st_reg <= lxb_pkg::LXB_PRECHARGING; // R4
                  t_reg <= `LXB_T_RP;
                  ap_reg <= 1'b0;
                end else begin
                  st_reg <= lxb_pkg::LXB_ACTIVE; // R4
                end
              end
              default: st_reg <= st_reg;
            endcase
          end
        end
      end
    end
  endgenerate

  assign all_idle = &idle_v;
  assign any_burst = |burst_v;

  // Beat may ride with its write command, before the bank shows writing
  assign beat_bank = (go && link.cmd == `LXB_CMD_WR) ? link.bank :
                     burst_bank_reg;
  assign beat_ok = burst_v[beat_bank] ||
                   (go && link.cmd == `LXB_CMD_WR && active_v[beat_bank]); // R21

  // Mask rides with its beat; no burst means no store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_data_reg <= '0;
      wr_store_reg <= 1'b0;
      wr_bank_reg <= '0;
    end else begin
      wr_store_reg <= link.wvalid && !link.wmask && beat_ok; // R21
      if (link.wvalid && !link.wmask) begin
        wr_data_reg <= link.wdata; // R21
        wr_bank_reg <= beat_bank;
      end
    end
  end
  assign wr_data = wr_data_reg;
  assign wr_store = wr_store_reg;
  assign wr_bank = wr_bank_reg;
endmodule // lxb_device
`default_nettype wire

/* lxb_defs.svh */
// Constants for the cross-bank command tracker
// Behaviour
// R1: Commands act only with clock enable high twice
// R2: Bank idle only after precharge time elapses
// R3: Active means row open, delay met, quiet
// R4: Reading or writing holds until burst ends
// R5: Refresh and mode writes need all banks idle
// R6: Burst terminate acts only on burst bank
// R7: During mode register access, send only NOP
// R8: Mode read returns prior state; write to idle
// R9: Controller spaces activates by activate delay
// R10: Reads and writes allowed with or without precharge
// R11: Precharge hits one bank or all banks
// R12: Mode read accepted while a bank activates
// R13: Mode read accepted while a bank precharges
// R14: After mode read, pending delays still complete
// R15: Write follows read completion or terminate
// R16: Read follows write completion or terminate
// R17: Other banks usable after auto precharge access
// R18: Reset is mode write with all banks idle
// R19: Terminate only while a burst runs
// R20: Other banks accept commands during bursts
// R21: Mask low stores beat, high drops it
// R22: Controller avoids every unlisted combination
// R23: Each bank keeps its own state record
`ifndef LXB_DEFS_SVH
`define LXB_DEFS_SVH
`define LXB_BANKS 8
`define LXB_BANK_W 3
`define LXB_DQ_W 16
`define LXB_CNT_W 8
`define LXB_T_RCD 8'h03
`define LXB_T_RP 8'h03
`define LXB_T_RRD 8'h02
`define LXB_T_MRR 8'h02
`define LXB_T_MRW 8'h05
`define LXB_T_BURST 8'h04
`define LXB_T_RESET 8'h0A
`define LXB_T_EXIT 8'h02
`define LXB_CMD_NOP 4'h0
`define LXB_CMD_ACT 4'h1
`define LXB_CMD_RD 4'h2
`define LXB_CMD_WR 4'h3
`define LXB_CMD_PRE 4'h4
`define LXB_CMD_PREA 4'h5
`define LXB_CMD_BST 4'h6
`define LXB_CMD_MRR 4'h7
`define LXB_CMD_MRW 4'h8
`define LXB_CMD_REF 4'h9
`define LXB_CMD_RESET 4'hA
`endif

/* lxb_pkg.sv */
// Bank state type used by the device end of the command link and by the bench
package lxb_pkg;
  typedef enum logic [3:0] {
    LXB_POWER_ON = 4'h0,
    LXB_RESETTING = 4'h1,
    LXB_IDLE = 4'h3,
    LXB_ACTIVATING = 4'h2,
    LXB_ACTIVE = 4'h6,
    LXB_READING = 4'h7,
    LXB_WRITING = 4'h5,
    LXB_PRECHARGING = 4'h4,
    LXB_MR_READING = 4'hC,
    LXB_MR_WRITING = 4'hD,
    LXB_REFRESHING = 4'hF
  } lxb_state_t;
endpackage

/* lxb_link_if.sv */
// Command, mask and data link between controller and device
`timescale 1ns/100ps
`default_nettype none
`include "lxb_defs.svh"
interface lxb_link_if;
  logic cke;
  logic [3:0] cmd;
  logic [`LXB_BANK_W-1:0] bank;
  logic auto_pre;
  logic [`LXB_DQ_W-1:0] wdata;
  logic wvalid;
  logic wmask;
  modport ctrl (output cke, cmd, bank, auto_pre, wdata, wvalid, wmask);
  modport dev (input cke, cmd, bank, auto_pre, wdata, wvalid, wmask);
endinterface
`default_nettype wire

/* lxb_ctrl.sv */
// Controller end: issues commands that pass coarse spacing, burst and idle checks, without per-bank state
`timescale 1ns/100ps
`default_nettype none
`include "lxb_defs.svh"
module lxb_ctrl #(
  parameter int BANKS = `LXB_BANKS
) (
  input wire logic clk,
  input wire logic rst_n,
  lxb_link_if.ctrl link,
  input wire logic req_valid,
  input wire logic [3:0] req_cmd,
  input wire logic [`LXB_BANK_W-1:0] req_bank,
  input wire logic req_auto_pre,
  input wire logic [`LXB_DQ_W-1:0] req_wdata,
  input wire logic req_wmask,
  output logic req_ready,
  input wire logic cke_req
);
  logic cke_reg;
  logic [3:0] cmd_reg;
  logic [`LXB_BANK_W-1:0] bank_reg;
  logic ap_reg;
  logic [`LXB_DQ_W-1:0] wdata_reg;
  logic wvalid_reg;
  logic wmask_reg;
  logic [`LXB_CNT_W-1:0] rrd_reg;
  logic [`LXB_CNT_W-1:0] quiet_reg;
  logic [`LXB_CNT_W-1:0] burst_reg;
  logic [`LXB_CNT_W-1:0] exit_reg;
  logic burst_wr_reg;
  logic all_idle_reg;
  logic legal;
  logic issue;

  // Coarse legality: the device does the fine per-bank tracking
  always_comb begin
    legal = 1'b0;
    unique case (req_cmd)
      `LXB_CMD_NOP: legal = 1'b1;
      `LXB_CMD_ACT: legal = (rrd_reg == 8'h00); // R9
      `LXB_CMD_RD: legal = (burst_reg == 8'h00) || !burst_wr_reg; // R16
      `LXB_CMD_WR: legal = (burst_reg == 8'h00) || burst_wr_reg; // R15
      `LXB_CMD_BST: legal = (burst_reg != 8'h00); // R19
      `LXB_CMD_PRE, `LXB_CMD_PREA, `LXB_CMD_MRR: legal = 1'b1; // R11 R17
      `LXB_CMD_MRW, `LXB_CMD_REF, `LXB_CMD_RESET:
        legal = all_idle_reg && (burst_reg == 8'h00); // R5 R18
      default: legal = 1'b0; // R22
    endcase
  end
  // Mode register access windows force NOP; clock enable must be settled
  assign req_ready = cke_reg && cke_req && (exit_reg == 8'h00) &&
                     (quiet_reg == 8'h00) && legal; // R1 R7
  assign issue = req_valid && req_ready && (req_cmd != `LXB_CMD_NOP);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_reg <= 1'b0;
      exit_reg <= `LXB_T_EXIT;
    end else begin
      cke_reg <= cke_req;
      if (!cke_reg) exit_reg <= `LXB_T_EXIT;
      else if (exit_reg != 8'h00) exit_reg <= exit_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= `LXB_CMD_NOP;
      bank_reg <= '0;
      ap_reg <= 1'b0;
      wdata_reg <= '0;
      wvalid_reg <= 1'b0;
      wmask_reg <= 1'b1;
    end else begin
      cmd_reg <= issue ? req_cmd : `LXB_CMD_NOP;
      bank_reg <= req_bank;
      ap_reg <= req_auto_pre; // R10
      wdata_reg <= req_wdata;
      wvalid_reg <= issue && (req_cmd == `LXB_CMD_WR);
      wmask_reg <= req_wmask; // R21
    end
  end

  // Timers that pace the command stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rrd_reg <= '0;
      quiet_reg <= '0;
      burst_reg <= '0;
      burst_wr_reg <= 1'b0;
      // No bank is open at power-on, so the first reset must pass
      all_idle_reg <= 1'b1;
    end else begin
      if (rrd_reg != 8'h00) rrd_reg <= rrd_reg - 8'h01;
      if (quiet_reg != 8'h00) quiet_reg <= quiet_reg - 8'h01;
      if (burst_reg != 8'h00) burst_reg <= burst_reg - 8'h01;
      if (issue) begin
        unique case (req_cmd)
          `LXB_CMD_ACT: begin
            rrd_reg <= `LXB_T_RRD; // R9
            all_idle_reg <= 1'b0;
          end
          `LXB_CMD_RD, `LXB_CMD_WR: begin
            burst_reg <= `LXB_T_BURST;
            burst_wr_reg <= (req_cmd == `LXB_CMD_WR);
          end
          `LXB_CMD_BST: burst_reg <= '0; // R19
          `LXB_CMD_MRR: quiet_reg <= `LXB_T_MRR; // R7
          `LXB_CMD_MRW, `LXB_CMD_REF: quiet_reg <= `LXB_T_MRW; // R7
          `LXB_CMD_RESET: begin
            quiet_reg <= `LXB_T_RESET;
            all_idle_reg <= 1'b1; // R18
          end
          `LXB_CMD_PREA: begin
            quiet_reg <= `LXB_T_RP; // R11
            all_idle_reg <= 1'b1;
          end
          default: quiet_reg <= quiet_reg;
        endcase
      end
    end
  end

  assign link.cke = cke_reg;
  assign link.cmd = cmd_reg;
  assign link.bank = bank_reg;
  assign link.auto_pre = ap_reg;
  assign link.wdata = wdata_reg;
  assign link.wvalid = wvalid_reg;
  assign link.wmask = wmask_reg;
endmodule // lxb_ctrl
`default_nettype wire

/* lxb_link_assertions.sv */
// Protocol checks on the command link between controller and device
`timescale 1ns/100ps
`default_nettype none
`include "lxb_defs.svh"
module lxb_link_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [`LXB_BANK_W-1:0] bank,
  input wire logic auto_pre,
  input wire logic [`LXB_DQ_W-1:0] wdata,
  input wire logic wvalid,
  input wire logic wmask
);
  logic [2:0] burst_reg;
  logic burst_rd_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mirror of the open burst, so order checks need no device state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_reg <= 3'h0;
    end else if (cmd == `LXB_CMD_RD || cmd == `LXB_CMD_WR) begin
      burst_reg <= 3'h4;
    end else if (cmd == `LXB_CMD_BST) begin
      burst_reg <= 3'h0;
    end else if (burst_reg != 3'h0) begin
      burst_reg <= burst_reg - 3'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_rd_reg <= 1'b0;
    end else if (cmd == `LXB_CMD_RD || cmd == `LXB_CMD_WR) begin
      burst_rd_reg <= (cmd == `LXB_CMD_RD);
    end
  end
  a_act_spacing: assert property (cmd == `LXB_CMD_ACT |=> cmd != `LXB_CMD_ACT)
    else $error("activates too close together");
  a_mrr_quiet: assert property (cmd == `LXB_CMD_MRR |=> cmd == `LXB_CMD_NOP)
    else $error("command during mode read");
  a_mrw_quiet: assert property (cmd == `LXB_CMD_MRW |=> (cmd == `LXB_CMD_NOP) [*4])
    else $error("command during mode write");
  a_ref_quiet: assert property (cmd == `LXB_CMD_REF |=> (cmd == `LXB_CMD_NOP) [*4])
    else $error("command during refresh");
  a_reset_quiet: assert property (cmd == `LXB_CMD_RESET |=> (cmd == `LXB_CMD_NOP) [*8])
    else $error("command during reset");
  a_cke_gate: assert property (!cke |-> cmd == `LXB_CMD_NOP)
    else $error("command with clock enable low");
  a_exit_wait: assert property ($rose(cke) |-> cmd == `LXB_CMD_NOP ##1 cmd == `LXB_CMD_NOP)
    else $error("command before exit time");
  a_bst_burst: assert property (cmd == `LXB_CMD_BST |-> burst_reg != 3'h0)
    else $error("terminate with no burst running");
  a_wr_after_rd: assert property (cmd == `LXB_CMD_WR |-> !(burst_rd_reg && burst_reg != 3'h0))
    else $error("write inside a read burst");
  a_rd_after_wr: assert property (cmd == `LXB_CMD_RD |-> !(!burst_rd_reg && burst_reg != 3'h0))
    else $error("read inside a write burst");
  c_bst: cover property (cmd == `LXB_CMD_BST);
  c_wr_ap: cover property (cmd == `LXB_CMD_WR && auto_pre);
  c_mrr: cover property (cmd == `LXB_CMD_MRR);
  c_beat: cover property (wvalid && !wmask);
endmodule // lxb_link_assertions
`default_nettype wire

/* tb_lpddr_cross_bank_command_rules.sv */
// Self-checking bench: controller and device joined over the link
`timescale 1ns/100ps
`default_nettype none
`include "lxb_defs.svh"
module tb_lpddr_cross_bank_command_rules;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_cmd = `LXB_CMD_NOP;
  logic [2:0] req_bank = 3'h0;
  logic req_auto_pre = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  logic req_wmask = 1'b1;
  logic cke_req = 1'b0;
  logic req_ready, all_idle, any_burst, wr_store;
  logic [31:0] bank_state;
  logic [15:0] wr_data;
  logic [2:0] wr_bank;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int k;
  lxb_link_if link ();
  lxb_ctrl i_lxb_ctrl (.clk(clk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_auto_pre(req_auto_pre),
    .req_wdata(req_wdata), .req_wmask(req_wmask), .req_ready(req_ready),
    .cke_req(cke_req));
  lxb_device i_lxb_device (.clk(clk), .rst_n(rst_n), .link(link),
    .bank_state(bank_state), .all_idle(all_idle), .any_burst(any_burst),
    .wr_data(wr_data), .wr_store(wr_store), .wr_bank(wr_bank));
  lxb_link_assertions i_lxb_link_assertions (.clk(clk), .rst_n(rst_n),
    .cke(link.cke), .cmd(link.cmd), .bank(link.bank), .auto_pre(link.auto_pre),
    .wdata(link.wdata), .wvalid(link.wvalid), .wmask(link.wmask));
  always #5 clk = ~clk;
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // A hung handshake must still reach the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("Error run length expected finish seen cycle limit");
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] st(input int b);
    return {12'h000, bank_state[4*b +: 4]};
  endfunction
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic ap,
      input logic [15:0] d, input logic m);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_auto_pre <= ap;
    req_wdata <= d;
    req_wmask <= m;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("request taken", 16'h0001, {15'h0000, req_ready});
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic go(input logic [3:0] c, input logic [2:0] b, input logic ap);
    issue(c, b, ap, 16'h0000, 1'b1);
  endtask
  task automatic poll(input int b, input logic [3:0] exp, input int lim);
    int n;
    n = 0;
    while (st(b) !== {12'h000, exp} && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("bank state", {12'h000, exp}, st(b));
  endtask
  task automatic stores(input int lim, output int cnt);
    cnt = 0;
    repeat (lim) begin
      @(negedge clk);
      if (wr_store === 1'b1) begin
        cnt++;
        chk("stored data", 16'hA5C3, wr_data);
        chk("stored bank", 16'h0001, {13'h0000, wr_bank});
      end
    end
  endtask
  task automatic done(input string t);
    $display("Test %s finished, mismatches %0d", t, n_mismatch);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    at(1);
    chk("bank 0", lxb_pkg::LXB_POWER_ON, st(0));
    chk("all idle", 16'h0000, {15'h0000, all_idle});
    chk("clock enable", 16'h0000, {15'h0000, link.cke});
    cke_req <= 1'b1;
    go(`LXB_CMD_RESET, 3'h0, 1'b0);
    at(2);
    chk("bank 0", lxb_pkg::LXB_RESETTING, st(0));
    poll(7, lxb_pkg::LXB_IDLE, 40);
    for (k = 0; k < 8; k++) chk("bank idle", lxb_pkg::LXB_IDLE, st(k));
    done("reset");
    go(`LXB_CMD_ACT, 3'h1, 1'b0);
    at(2);
    chk("bank 1", lxb_pkg::LXB_ACTIVATING, st(1));
    at(2);
    chk("bank 1", lxb_pkg::LXB_ACTIVATING, st(1));
    at(1);
    chk("bank 1", lxb_pkg::LXB_ACTIVE, st(1));
    chk("bank 0", lxb_pkg::LXB_IDLE, st(0));
    go(`LXB_CMD_ACT, 3'h2, 1'b0);
    go(`LXB_CMD_MRR, 3'h2, 1'b0);
    at(2);
    chk("bank 2", lxb_pkg::LXB_MR_READING, st(2));
    poll(2, lxb_pkg::LXB_ACTIVE, 20);
    done("activate");
    go(`LXB_CMD_RD, 3'h2, 1'b0);
    at(2);
    chk("burst flag", 16'h0001, {15'h0000, any_burst});
    at(3);
    chk("bank 2", lxb_pkg::LXB_READING, st(2));
    at(1);
    chk("bank 2", lxb_pkg::LXB_ACTIVE, st(2));
    go(`LXB_CMD_RD, 3'h1, 1'b0);
    go(`LXB_CMD_BST, 3'h1, 1'b0);
    at(2);
    chk("bank 1", lxb_pkg::LXB_ACTIVE, st(1));
    go(`LXB_CMD_RD, 3'h2, 1'b1);
    go(`LXB_CMD_RD, 3'h1, 1'b0);
    at(2);
    chk("bank 1", lxb_pkg::LXB_READING, st(1));
    poll(2, lxb_pkg::LXB_IDLE, 20);
    poll(1, lxb_pkg::LXB_ACTIVE, 20);
    done("bursts");
    issue(`LXB_CMD_WR, 3'h1, 1'b0, 16'hA5C3, 1'b0);
    stores(10, k);
    chk("store count", 16'h0001, k[15:0]);
    poll(1, lxb_pkg::LXB_ACTIVE, 20);
    issue(`LXB_CMD_WR, 3'h1, 1'b0, 16'h5A3C, 1'b1);
    stores(10, k);
    chk("masked count", 16'h0000, k[15:0]);
    done("mask");
    poll(1, lxb_pkg::LXB_ACTIVE, 20);
    go(`LXB_CMD_PREA, 3'h0, 1'b0);
    at(2);
    chk("bank 1", lxb_pkg::LXB_PRECHARGING, st(1));
    go(`LXB_CMD_MRR, 3'h1, 1'b0);
    poll(1, lxb_pkg::LXB_IDLE, 20);
    poll(7, lxb_pkg::LXB_IDLE, 20);
    chk("all idle", 16'h0001, {15'h0000, all_idle});
    go(`LXB_CMD_REF, 3'h0, 1'b0);
    at(2);
    chk("bank 0", lxb_pkg::LXB_REFRESHING, st(0));
    poll(0, lxb_pkg::LXB_IDLE, 20);
    go(`LXB_CMD_MRW, 3'h0, 1'b0);
    at(2);
    chk("bank 0", lxb_pkg::LXB_MR_WRITING, st(0));
    poll(0, lxb_pkg::LXB_IDLE, 20);
    done("precharge and mode");
    summarize();
  end
endmodule // tb_lpddr_cross_bank_command_rules
`default_nettype wire
